// ### logic/cfs_pkg.sv
package cfs_pkg;

    // Register byte offsets on the AXI4-Lite slave.
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;

    // Control register field positions.
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_SEL_W   = 5;
    localparam int CTRL_FS_BIT  = 8;

    // Control register reset value: running code, shutdown pin released.
    localparam logic [31:0] CTRL_RESET = 32'h0000_0100;

    // Voltage-select code that requests shutdown.
    localparam logic [4:0] SEL_SHUTDOWN = 5'h1F;

    // Timing counts in phase clock pulses.
    localparam int SOFT_START_BITS = 11;
    localparam int WAIT_CYCLES     = 2048;
    localparam int MAX_RETRIES     = 7;
    localparam int STEP_CYCLES     = 2;

    // Analog thresholds, kept for reference in millivolts or microamps.
    localparam int LOW_OFFSET_MV   = 350;
    localparam int HIGH_LIMIT_MV   = 2200;
    localparam int ENABLE_MV       = 1230;
    localparam int OVERLOAD_UA     = 90;
    localparam int STEP_MV         = 25;

    // Default phase clock divide from the 50 MHz aclk.
    localparam int PHASE_DIV = 100;

    // PWM output state.
    typedef enum logic [1:0] {
        CFS_PWM_RUN  = 2'b00,
        CFS_PWM_LOW  = 2'b01,
        CFS_PWM_HIZ  = 2'b10
    } cfs_pwm_t;

    // Synchronised comparator results travel together.
    typedef struct packed {
        logic below_low;    // Offset output under the reference.
        logic above_high;   // Sense amplifier at the high limit.
        logic at_reference; // Output has fallen to the reference.
        logic overload;     // Mean current above the limit.
    } cfs_cmp_t;

endpackage : cfs_pkg

// ### logic/cfs_supervisor.sv
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Window-ok low in shutdown, rises in soft-start once output clears low limit.
// - Once high, window-ok falls only on disable, under-voltage or a fault.
// - Low limit compares output plus 350mV against the reference.
// - Under-voltage drops window-ok at once; switching continues.
// - Window-ok returns high once output exceeds the low limit again.
// - When disabled while running, window-ok holds until output decays below limit.
// - Sense level at 2.2V drops window-ok immediately as over-voltage.
// - Over-voltage forces all PWM outputs low.
// - PWM low until output reaches reference, then hi-Z; low again on recurrence.
// - Over-voltage drives the crowbar gate output high.
// - Over-voltage latches: switching stops and window-ok stays low until reset.
// - Latches clear only on enable below 1.23V or bias below reset threshold.
// - Mean current above 90uA reference triggers shutdown.
// - Overload trip: PWM hi-Z, window-ok low for 2048 phase clocks, then soft-start.
// - Overload during soft-start trips at once and repeats the wait.
// - Seven retries allowed; the eighth failed attempt latches off.
// - A clean soft-start resumes operation, raises window-ok, clears retries.
// - Overload result is blanked while the reference is stepping.
// - Soft-start timed by an 11-bit counter on phase clock pulses.
// - All-ones select code means shutdown; any other code restarts.
// - Reference steps every two cycles; this stepping is the blanking window.
module cfs_supervisor #(
    parameter int PHASE_DIV = cfs_pkg::PHASE_DIV
) (
    input  wire logic        aclk,            // System clock, 50 MHz.
    input  wire logic        aresetn,         // Synchronous reset, active low.
    input  wire logic        enable_ok,       // Enable above threshold and bias good.
    input  wire logic        below_low_in,    // Comparator: offset output under ref.
    input  wire logic        above_high_in,   // Comparator: sense level at high limit.
    input  wire logic        at_ref_in,       // Comparator: output at reference.
    input  wire logic        overload_in,     // Comparator: mean current over limit.
    input  wire logic        ref_stepping_in, // Reference transition in progress.
    output logic             window_ok_out,   // Window-ok, open-drain output value.
    output logic             window_ok_oe,    // Window-ok pull-down enable.
    output logic             crowbar_gate_out,// Crowbar gate drive.
    output cfs_pkg::cfs_pwm_t pwm_state,      // PWM output state.
    output logic             latched_off,     // Overload lockout indicator.
    input  wire logic [31:0] s_axi_awaddr,    // Write address.
    input  wire logic        s_axi_awvalid,   // Write address valid.
    output logic             s_axi_awready,   // Write address ready.
    input  wire logic [31:0] s_axi_wdata,     // Write data.
    input  wire logic [3:0]  s_axi_wstrb,     // Write strobes.
    input  wire logic        s_axi_wvalid,    // Write data valid.
    output logic             s_axi_wready,    // Write data ready.
    output logic [1:0]       s_axi_bresp,     // Write response.
    output logic             s_axi_bvalid,    // Write response valid.
    input  wire logic        s_axi_bready,    // Write response ready.
    input  wire logic [31:0] s_axi_araddr,    // Read address.
    input  wire logic        s_axi_arvalid,   // Read address valid.
    output logic             s_axi_arready,   // Read address ready.
    output logic [31:0]      s_axi_rdata,     // Read data.
    output logic [1:0]       s_axi_rresp,     // Read response.
    output logic             s_axi_rvalid,    // Read data valid.
    input  wire logic        s_axi_rready     // Read data ready.
);

    typedef enum logic [2:0] {
        ST_OFF   = 3'b000,
        ST_SOFT  = 3'b001,
        ST_RUN   = 3'b010,
        ST_WAIT  = 3'b011,
        ST_OVER  = 3'b100,
        ST_LOCK  = 3'b101
    } cfs_state_t;

    // Divider width, worked out once so that every compare against it is sized on purpose.
    localparam int DIV_W = $clog2(PHASE_DIV);

    cfs_state_t                         state;
    cfs_pkg::cfs_cmp_t                  cmp;
    logic                               enable_s;
    logic                               stepping_s;
    logic [31:0]                        ctrl;
    logic [DIV_W-1:0]                   div_cnt;
    logic                               phase_tick;
    logic [cfs_pkg::SOFT_START_BITS-1:0] timer;
    logic [2:0]                         retries;
    logic                               pwm_low;
    logic                               window_ok;
    logic                               shutdown_req;
    logic                               trip;
    logic                               aw_held;
    logic                               w_held;
    logic [7:0]                         aw_addr;
    logic [31:0]                        w_data;
    logic [3:0]                         w_strb;

    // Comparator results cross into aclk before any decision reads them.
    cfs_sync #(.W(6)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .d       ({below_low_in, above_high_in, at_ref_in, overload_in,
                   enable_ok, ref_stepping_in}),
        .q       ({cmp.below_low, cmp.above_high, cmp.at_reference, cmp.overload,
                   enable_s, stepping_s})
    );

    // Phase clock enable; the real phase clock is slower than aclk.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt    <= '0;
            phase_tick <= 1'b0;
        end else begin
            phase_tick <= (div_cnt == DIV_W'(PHASE_DIV - 1));
            if (div_cnt == DIV_W'(PHASE_DIV - 1)) begin
                div_cnt <= '0;
            end else begin
                div_cnt <= div_cnt + 1'b1;
            end
        end
    end

    // All-ones select code or the grounded frequency pin request shutdown.
    assign shutdown_req = (ctrl[cfs_pkg::CTRL_SEL_LSB +: cfs_pkg::CTRL_SEL_W]
                           == cfs_pkg::SEL_SHUTDOWN) || !ctrl[cfs_pkg::CTRL_FS_BIT];

    // Overload is ignored while the reference is stepping, to avoid nuisance trips.
    assign trip = cmp.overload && !stepping_s;

    // Main fault sequencer. Reset and enable low are the only exits from the latched states,
    // which is why no other branch ever leaves ST_OVER or ST_LOCK.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state   <= ST_OFF;
            timer   <= '0;
            retries <= '0;
        end else if (!enable_s) begin
            state   <= ST_OFF;
            timer   <= '0;
            retries <= '0;
        end else if (cmp.above_high && state != ST_OFF && state != ST_LOCK) begin
            state <= ST_OVER;
        end else begin
            unique case (state)
                ST_OFF: begin
                    if (!shutdown_req) begin
                        state <= ST_SOFT;
                        timer <= '0;
                    end
                end
                ST_SOFT: begin
                    if (shutdown_req) begin
                        state <= ST_OFF;
                    end else if (trip) begin
                        // Eighth failed attempt locks out.
                        timer <= '0;
                        if (retries == 3'(cfs_pkg::MAX_RETRIES)) begin
                            state <= ST_LOCK;
                        end else begin
                            state   <= ST_WAIT;
                            retries <= retries + 1'b1;
                        end
                    end else if (phase_tick) begin
                        timer <= timer + 1'b1;
                        if (timer == '1) begin
                            state   <= ST_RUN;
                            retries <= '0;
                        end
                    end
                end
                ST_RUN: begin
                    if (shutdown_req) begin
                        state <= ST_OFF;
                    end else if (trip) begin
                        state <= ST_WAIT;
                        timer <= '0;
                        if (retries == 3'(cfs_pkg::MAX_RETRIES)) begin
                            state <= ST_LOCK;
                        end else begin
                            retries <= retries + 1'b1;
                        end
                    end
                end
                ST_WAIT: begin
                    // Wait 2048 phase clocks then retry soft-start.
                    if (phase_tick) begin
                        timer <= timer + 1'b1;
                        if (timer == '1) begin
                            state <= ST_SOFT;
                        end
                    end
                end
                ST_OVER: begin
                end
                ST_LOCK: begin
                end
                default: begin
                    state <= ST_OFF;
                end
            endcase
        end
    end

    // Over-voltage PWM pull-down: low while above reference, hi-Z once at
    // reference, low again whenever the high limit is hit again.
    always_ff @(posedge aclk) begin
        if (!aresetn || !enable_s) begin
            pwm_low <= 1'b0;
        end else if (cmp.above_high && state != ST_OFF && state != ST_LOCK) begin
            pwm_low <= 1'b1;
        end else if (cmp.at_reference) begin
            pwm_low <= 1'b0;
        end
    end

    // Window-ok: set once the output clears the low limit in soft-start or run,
    // drops on under-voltage, faults and shutdown after decay.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            window_ok <= 1'b0;
        end else begin
            unique case (state)
                ST_SOFT, ST_RUN: window_ok <= !cmp.below_low && !cmp.above_high
                                              && !trip;
                ST_OFF:  window_ok <= window_ok && !cmp.below_low;
                default: window_ok <= 1'b0;
            endcase
        end
    end

    // Outputs come straight from state flops.
    always_comb begin
        window_ok_out    = window_ok;
        window_ok_oe     = !window_ok;
        crowbar_gate_out = (state == ST_OVER);
        latched_off      = (state == ST_LOCK);
        if (state == ST_OVER) begin
            pwm_state = pwm_low ? cfs_pkg::CFS_PWM_LOW : cfs_pkg::CFS_PWM_HIZ;
        end else if (state == ST_SOFT || state == ST_RUN) begin
            pwm_state = cfs_pkg::CFS_PWM_RUN;
        end else begin
            pwm_state = cfs_pkg::CFS_PWM_HIZ;
        end
    end

    // AXI write side: address and data held independently, one response.
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_bresp   = 2'b00;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= '0;
            w_data       <= '0;
            w_strb       <= '0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (aw_held && w_held) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Control register; writes to other offsets are accepted and dropped.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= cfs_pkg::CTRL_RESET;
        end else if (aw_held && w_held && aw_addr == cfs_pkg::CTRL_OFFSET) begin
            for (int i = 0; i < 4; i++) begin
                if (w_strb[i]) begin
                    ctrl[8*i +: 8] <= w_data[8*i +: 8];
                end
            end
        end
    end

    // AXI read side: status shows live state; unmapped reads return zero.
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rresp   = 2'b00;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            if (s_axi_araddr[7:0] == cfs_pkg::CTRL_OFFSET) begin
                s_axi_rdata <= {23'h0, ctrl[8:0]};
            end else if (s_axi_araddr[7:0] == cfs_pkg::STATUS_OFFSET) begin
                s_axi_rdata <= {22'h0, retries, pwm_state, state, window_ok, 1'b0};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Over-voltage raises the crowbar within three cycles of the comparator.
    chk_crowbar_on_ov: assert property (@(posedge aclk) disable iff (!aresetn)
        (above_high_in && enable_ok && state inside {ST_SOFT, ST_RUN})[*3]
        |-> ##1 crowbar_gate_out)
        else $error("crowbar not raised on over-voltage");

    chk_ov_window_low: assert property (@(posedge aclk) disable iff (!aresetn)
        crowbar_gate_out |-> !window_ok_out)
        else $error("window-ok high during over-voltage latch");

    chk_ov_latch_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == ST_OVER && enable_s) |=> state == ST_OVER)
        else $error("over-voltage latch left without reset");

    chk_lock_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == ST_LOCK && enable_s) |=> state == ST_LOCK)
        else $error("lockout left without reset");

    chk_wait_hiz: assert property (@(posedge aclk) disable iff (!aresetn)
        state == ST_WAIT |-> pwm_state == cfs_pkg::CFS_PWM_HIZ && !window_ok_out)
        else $error("wait state not hi-Z with window-ok low");

    chk_blank_trip: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == ST_RUN && stepping_s && !cmp.above_high && !shutdown_req && enable_s)
        |=> state == ST_RUN)
        else $error("overload tripped during reference stepping");

    chk_retry_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        ($past(state) == ST_SOFT && state == ST_RUN) |-> retries == 3'h0)
        else $error("retry count not cleared after clean soft-start");

    chk_uv_drop: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == ST_RUN && cmp.below_low) |=> !window_ok_out
        || state != ST_RUN)
        else $error("window-ok held during under-voltage");

    chk_shutdown_code: assert property (@(posedge aclk) disable iff (!aresetn)
        (state == ST_RUN && shutdown_req && enable_s && !cmp.above_high)
        |=> state == ST_OFF)
        else $error("shutdown code ignored");

endmodule : cfs_supervisor

`default_nettype wire

// ### logic/cfs_sync.sv
`timescale 1ns/100ps
`default_nettype none

module cfs_sync #(
    parameter int W = 4
) (
    input  wire logic         aclk,    // System clock.
    input  wire logic         aresetn, // Synchronous reset, active low.
    input  wire logic [W-1:0] d,       // Asynchronous inputs.
    output logic      [W-1:0] q        // Synchronised outputs.
);

    logic [W-1:0] stage1;

    // Two flops; only the second stage is read outside.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1 <= '0;
            q      <= '0;
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end

endmodule : cfs_sync

`default_nettype wire

// ### verif/cfs_plant.sv
`timescale 1ns/100ps
`default_nettype none

// Rail, drivers and monitor pull-up seen from the supervisor's pins.
module cfs_plant (
    input  wire logic              aclk,         // System clock.
    input  wire logic              aresetn,      // Reset, active low.
    input  wire cfs_pkg::cfs_pwm_t pwm_state,    // Driver command.
    input  wire logic              window_ok_oe, // Window-ok pull-down.
    input  wire logic              surge,        // Kick rail over the high limit.
    input  wire logic              sag,          // Kick rail under the low limit.
    input  wire logic              slow,         // Slow rail response.
    input  wire logic              load_fault,   // Heavy load.
    output logic                   below_low,    // Rail plus offset under reference.
    output logic                   above_high,   // Rail at the high limit.
    output logic                   at_ref,       // Rail at or under reference.
    output logic                   overload,     // Mean current over limit.
    output logic                   window_ok_out_line,   // Resolved open-drain wire.
    output int                     lvl           // Rail level, reference is 100.
);
    logic [1:0] div;

    // The rail moves as the drivers act or on a surge or sag kick; a slow rail steps one cycle in four.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lvl <= 0;
            div <= 2'h0;
        end else begin
            div <= div + 2'h1;
            if (surge) begin
                lvl <= 230;
            end else if (sag) begin
                lvl <= 40;
            end else if (!slow || div == 2'h0) begin
                case (pwm_state)
                    cfs_pkg::CFS_PWM_RUN: lvl <= lvl + ((lvl < 100) ? 1 : ((lvl > 100) ? -1 : 0));
                    cfs_pkg::CFS_PWM_LOW: lvl <= (lvl > 1) ? lvl - 2 : 0;
                    default:              lvl <= (lvl > 0) ? lvl - 1 : 0;
                endcase
            end
        end
    end

    // The low limit sits 35 units under the reference.
    assign below_low  = (lvl + 35) < 100;
    assign above_high = lvl >= 220;
    assign at_ref     = lvl <= 100;
    assign overload   = load_fault;
    // A released wire is pulled high by the monitor.
    assign window_ok_out_line = window_ok_oe ? 1'b0 : 1'b1;
endmodule : cfs_plant

`default_nettype wire

// ### verif/tb_converter_fault_supervisor.sv
`timescale 1ns/100ps
`default_nettype none

module tb_converter_fault_supervisor;
    localparam int PD = 2;
    localparam int WC = cfs_pkg::WAIT_CYCLES * PD; // One wait in aclk cycles.
    localparam logic [31:0] CTRL = 32'(cfs_pkg::CTRL_OFFSET);
    localparam logic [31:0] STAT = 32'(cfs_pkg::STATUS_OFFSET);
    typedef struct {string name; logic [31:0] v; logic [31:0] m;} cfs_note_t;
    logic aclk, aresetn, enable_ok, ref_stepping_in, surge, sag, slow, load_fault;
    logic below_low_in, above_high_in, at_ref_in, overload_in, window_ok_out_line, latched_off;
    logic window_ok_out, window_ok_oe, crowbar_gate_out, s_axi_awvalid, s_axi_awready;
    logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [4:0]  sel;
    cfs_pkg::cfs_pwm_t pwm_state;
    int lvl, mismatches, checks_done, n;
    time t0;
    cfs_note_t notes[$];

    cfs_supervisor #(.PHASE_DIV(PD)) u_dut (.aclk, .aresetn, .enable_ok, .below_low_in,
        .above_high_in, .at_ref_in, .overload_in, .ref_stepping_in, .window_ok_out,
        .window_ok_oe, .crowbar_gate_out, .pwm_state, .latched_off, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);

    cfs_plant u_plant (.aclk, .aresetn, .pwm_state, .window_ok_oe, .surge, .sag, .slow,
        .load_fault, .below_low(below_low_in), .above_high(above_high_in),
        .at_ref(at_ref_in), .overload(overload_in), .window_ok_out_line, .lvl);

    // Clock of 20 ns.
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : chk

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    // Each item holds until taken; bready or rready holds until the answer.
    task automatic axi(input bit wr, input logic [31:0] a, input logic [31:0] d,
                       input logic [31:0] m, input string name);
        int k = 0;
        @(posedge aclk);
        if (wr) notes.push_back('{"bresp", 32'h0, 32'h3});
        else notes.push_back('{name, d, m});
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
        {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
        do begin
            @(posedge aclk);
            k++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while ((wr ? s_axi_bvalid : s_axi_rvalid) !== 1'b1 && k < 100);
        {s_axi_bready, s_axi_rready} <= 2'b00;
        chk("valid rresp", 32'h1, {29'h0, s_axi_rresp, wr ? s_axi_bvalid : s_axi_rvalid});
    endtask : axi

    // Bounded wait, then compare.
    task automatic wait_for(input bit pw, input logic [1:0] v, input int lim);
        int k = 0;
        while ((pw ? pwm_state : {1'b0, window_ok_out}) !== v && k < lim) begin
            @(posedge aclk);
            k++;
        end
        chk(pw ? "pwm_state" : "window_ok_out", {30'h0, v}, {30'h0, pw ? pwm_state : {1'b0, window_ok_out}});
    endtask : wait_for

    // Each answer meets the oldest note.
    always @(posedge aclk) begin
        if (((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) && notes.size() > 0) begin
            chk(notes[0].name, notes[0].v, s_axi_rvalid ? s_axi_rdata & notes[0].m : {30'h0, s_axi_bresp});
            void'(notes.pop_front());
        end
    end

    // Watchdog sized at about one and a half times the expected run.
    initial begin
        repeat (20 * WC) @(posedge aclk);
        mismatches++;
        finish_test();
    end

    initial begin
        {aresetn, enable_ok, ref_stepping_in, surge, sag, slow, load_fault} = 7'h00;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        void'($urandom(85));
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("reset outputs", 32'h4, {27'h0, window_ok_out, crowbar_gate_out, pwm_state, latched_off});
        chk("window_ok_out_line", 32'h0, {31'h0, window_ok_out_line});
        axi(1'b0, CTRL, cfs_pkg::CTRL_RESET, 32'hFFFF_FFFF, "ctrl reset");
        axi(1'b1, 32'h20, 32'hFFFF_FFFF, '0, "");
        axi(1'b0, 32'h20, 32'h0, 32'hFFFF_FFFF, "unmapped");
        axi(1'b0, CTRL, cfs_pkg::CTRL_RESET, 32'hFFFF_FFFF, "ctrl kept");
        enable_ok <= 1'b1;
        wait_for(1'b1, cfs_pkg::CFS_PWM_RUN, 20);
        wait_for(1'b0, 2'h1, 300);
        chk("rail_up", 32'h1, {31'h0, (lvl + 35 >= 100)});
        repeat (WC + 20) @(posedge aclk);
        axi(1'b0, STAT, 32'h00A, 32'h3FE, "status run");
        // Running codes keep the converter switching.
        for (int i = 0; i < 3; i++) begin
            sel = 5'($urandom_range(30, 0));
            axi(1'b1, CTRL, {23'h0, 1'b1, 3'h0, sel}, '0, "");
            axi(1'b0, CTRL, {23'h0, 1'b1, 3'h0, sel}, 32'h11F, "ctrl code");
            chk("pwm_state", 32'h0, {30'h0, pwm_state});
        end
        sag <= 1'b1;
        @(posedge aclk);
        sag <= 1'b0;
        wait_for(1'b0, 2'h0, 8);
        chk("pwm_state", 32'h0, {30'h0, pwm_state});
        wait_for(1'b0, 2'h1, 120);
        ref_stepping_in <= 1'b1;
        repeat (3) @(posedge aclk);
        load_fault <= 1'b1;
        repeat (20) @(posedge aclk);
        chk("blanked", 32'h1, {29'h0, pwm_state, window_ok_out});
        load_fault <= 1'b0;
        repeat (5) @(posedge aclk);
        ref_stepping_in <= 1'b0;
        axi(1'b1, CTRL, {23'h0, 1'b1, 3'h0, cfs_pkg::SEL_SHUTDOWN}, '0, "");
        wait_for(1'b1, cfs_pkg::CFS_PWM_HIZ, 10);
        chk("window_ok_out", 32'h1, {31'h0, window_ok_out});
        wait_for(1'b0, 2'h0, 80);
        axi(1'b0, STAT, 32'h040, 32'h3FE, "status off");
        axi(1'b1, CTRL, 32'h0000_0105, '0, "");
        wait_for(1'b1, cfs_pkg::CFS_PWM_RUN, 10);
        repeat (WC + 20) @(posedge aclk);
        // Over-voltage twice, the second time with a slow rail.
        for (int i = 0; i < 2; i++) begin
            slow  <= i[0];
            surge <= 1'b1;
            @(posedge aclk);
            surge <= 1'b0;
            wait_for(1'b1, cfs_pkg::CFS_PWM_LOW, 8);
            chk("ovp_flags", 32'h1, {30'h0, window_ok_out, crowbar_gate_out});
            wait_for(1'b1, cfs_pkg::CFS_PWM_HIZ, 400);
            chk("rail_at_ref", 32'h1, {31'h0, (lvl <= 100)});
        end
        slow <= 1'b0;
        repeat (50) @(posedge aclk);
        chk("ovp latch", 32'h5, {29'h0, pwm_state, crowbar_gate_out});
        chk("window_ok_out", 32'h0, {31'h0, window_ok_out});
        enable_ok <= 1'b0;
        repeat (6) @(posedge aclk);
        chk("crowbar_gate_out", 32'h0, {31'h0, crowbar_gate_out});
        enable_ok <= 1'b1;
        repeat (WC + 200) @(posedge aclk);
        load_fault <= 1'b1;
        wait_for(1'b1, cfs_pkg::CFS_PWM_HIZ, 8);
        t0 = $time;
        load_fault <= 1'b0;
        axi(1'b0, STAT, 32'h0CC, 32'h3FE, "status wait");
        wait_for(1'b1, cfs_pkg::CFS_PWM_RUN, WC + 50);
        n = int'(($time - t0) / 20);
        chk("wait length", 32'h1, {31'h0, (n >= WC - 8 && n <= WC + 8)});
        repeat (WC + 20) @(posedge aclk);
        axi(1'b0, STAT, 32'h00A, 32'h3FE, "status recovered");
        load_fault <= 1'b1;
        wait_for(1'b1, cfs_pkg::CFS_PWM_HIZ, 8);
        wait_for(1'b1, cfs_pkg::CFS_PWM_RUN, WC + 50);
        wait_for(1'b1, cfs_pkg::CFS_PWM_HIZ, 8);
        repeat (5 * WC + WC / 2) @(posedge aclk);
        chk("latched_off", 32'h0, {31'h0, latched_off});
        repeat (2 * WC) @(posedge aclk);
        chk("lockout", 32'h5, {29'h0, pwm_state, latched_off});
        load_fault <= 1'b0;
        enable_ok  <= 1'b0;
        repeat (6) @(posedge aclk);
        chk("latched_off", 32'h0, {31'h0, latched_off});
        finish_test();
    end
endmodule : tb_converter_fault_supervisor

`default_nettype wire
